// ---- hw/lde_defines.vh ----
// Constants shared by the rate 223/255 LDPC encoder files
`ifndef LDE_DEFINES_VH
`define LDE_DEFINES_VH

// Circulant geometry
`define LDE_CIRC 511
`define LDE_CIRC_LAST 510
`define LDE_NBLK 14
`define LDE_NBLK_LAST 13
`define LDE_HBLK 16

// Frame and codeword lengths in bits
`define LDE_FILL 18
`define LDE_MSG 7136
`define LDE_PAR 1022
`define LDE_PAR_LAST 1021
`define LDE_TAIL 2
`define LDE_OUT 8160

// Parity elements forced to zero in every generator row
`define LDE_ZERO_EL0 510
`define LDE_ZERO_EL1 1021

// Widths
`define LDE_POS_W 9
`define LDE_BLK_W 4
`define LDE_PCNT_W 10

`endif

// ---- hw/lde_gen_mem.v ----
// Generator first-row memory, one word per information block
`timescale 1ns/10ps
module lde_gen_mem #(
    parameter WIDTH = 1022,
    parameter DEPTH = 14,
    parameter AW = 4
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Write port
    input wire i_wr_en,
    input wire [AW-1:0] i_wr_addr,
    input wire [WIDTH-1:0] i_wr_data,
    // Read port, one cycle latency
    input wire [AW-1:0] i_rd_addr,
    output wire [WIDTH-1:0] o_rd_data
);

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [WIDTH-1:0] rd_data_reg;

    // Storage write, out of range addresses dropped
    always @(posedge i_clk) begin
        if (i_wr_en && (i_wr_addr < DEPTH)) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read, zero beyond depth
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            rd_data_reg <= {WIDTH{1'b0}};
        end else if (i_rd_addr < DEPTH) begin
            rd_data_reg <= mem_reg[i_rd_addr];
        end else begin
            rd_data_reg <= {WIDTH{1'b0}};
        end
    end

    assign o_rd_data = rd_data_reg;

endmodule

// ---- hw/lde_syn_check.v ----
// Bit-serial syndrome of the parity check matrix over a codeword
`timescale 1ns/10ps
`include "lde_defines.vh"
module lde_syn_check (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Column stream
    input wire i_clear,
    input wire i_en,
    input wire i_bit,
    input wire [3:0] i_blk,
    input wire [8:0] i_col,
    // Result
    output wire o_zero
);

    reg [1021:0] syn_reg;
    reg [1021:0] syn_next;
    reg [17:0] pair0;
    reg [17:0] pair1;

    // First-row one positions of each circulant, upper then lower
    function [17:0] chk_pair;
        input [4:0] idx;
        begin
            case (idx)
                5'h00: chk_pair = {9'd0, 9'd176};
                5'h01: chk_pair = {9'd12, 9'd239};
                5'h02: chk_pair = {9'd0, 9'd352};
                5'h03: chk_pair = {9'd24, 9'd431};
                5'h04: chk_pair = {9'd0, 9'd392};
                5'h05: chk_pair = {9'd151, 9'd409};
                5'h06: chk_pair = {9'd0, 9'd351};
                5'h07: chk_pair = {9'd9, 9'd359};
                5'h08: chk_pair = {9'd0, 9'd307};
                5'h09: chk_pair = {9'd53, 9'd329};
                5'h0a: chk_pair = {9'd0, 9'd207};
                5'h0b: chk_pair = {9'd18, 9'd281};
                5'h0c: chk_pair = {9'd0, 9'd399};
                5'h0d: chk_pair = {9'd202, 9'd457};
                5'h0e: chk_pair = {9'd0, 9'd247};
                5'h0f: chk_pair = {9'd36, 9'd261};
                5'h10: chk_pair = {9'd99, 9'd471};
                5'h11: chk_pair = {9'd130, 9'd473};
                5'h12: chk_pair = {9'd198, 9'd435};
                5'h13: chk_pair = {9'd260, 9'd478};
                5'h14: chk_pair = {9'd215, 9'd420};
                5'h15: chk_pair = {9'd282, 9'd481};
                5'h16: chk_pair = {9'd48, 9'd396};
                5'h17: chk_pair = {9'd193, 9'd445};
                5'h18: chk_pair = {9'd273, 9'd430};
                5'h19: chk_pair = {9'd302, 9'd451};
                5'h1a: chk_pair = {9'd96, 9'd379};
                5'h1b: chk_pair = {9'd191, 9'd386};
                5'h1c: chk_pair = {9'd244, 9'd467};
                5'h1d: chk_pair = {9'd364, 9'd470};
                5'h1e: chk_pair = {9'd51, 9'd382};
                default: chk_pair = {9'd192, 9'd414};
            endcase
        end
    endfunction

    // Row hit by a column, modulo the circulant size
    function [9:0] circ_row;
        input [8:0] col;
        input [8:0] pos;
        input half;
        reg [9:0] t;
        begin
            t = {1'b0, col} + 10'd511 - {1'b0, pos};
            if (t >= 10'd511) begin
                t = t - 10'd511;
            end
            circ_row = half ? (t + 10'd511) : t;
        end
    endfunction

    // Each set column toggles two rows in each row block
    always @* begin
        syn_next = syn_reg;
        pair0 = chk_pair({1'b0, i_blk});
        pair1 = chk_pair({1'b1, i_blk});
        if (i_en && i_bit) begin
            syn_next[circ_row(i_col, pair0[17:9], 1'b0)] = ~syn_reg[circ_row(i_col, pair0[17:9], 1'b0)];
            syn_next[circ_row(i_col, pair0[8:0], 1'b0)] = ~syn_reg[circ_row(i_col, pair0[8:0], 1'b0)];
            syn_next[circ_row(i_col, pair1[17:9], 1'b1)] = ~syn_reg[circ_row(i_col, pair1[17:9], 1'b1)];
            syn_next[circ_row(i_col, pair1[8:0], 1'b1)] = ~syn_reg[circ_row(i_col, pair1[8:0], 1'b1)];
        end
    end

    // Syndrome register
    always @(posedge i_clk) begin
        if (!i_rstn || i_clear) begin
            syn_reg <= 1022'd0;
        end else begin
            syn_reg <= syn_next;
        end
    end

    assign o_zero = ~|syn_reg;

endmodule

// ---- hw/lde_encoder.v ----
// Systematic quasi-cyclic LDPC (8160,7136) encoder, bit serial
`timescale 1ns/10ps
`include "lde_defines.vh"
// Overview of operation
// - Circulants are 511 square, each row the previous rotated right one place
// - Every parity check circulant has two ones per row, row weight 32
// - Local one positions run from 0 to 510 inside each circulant
// - Check circulant first rows follow the fixed table of position pairs
// - Absolute check columns span 0 to 8175, local plus block offset
// - Information bits pass through unchanged as the systematic part
// - Each of 14 input blocks adds through two generator first rows
// - Generator rows solve the check equations; elements 510 and 1021 forced zero
// - Exactly 7136 frame bits are taken per codeword
// - Eighteen virtual zeros precede the frame bits in the information vector
// - Encoding yields fill zeros, message bits, then 1022 parity bits
// - Fill zeros dropped, two zeros appended, 8160 bits sent
module lde_encoder #(
    parameter GEN_W = 1022,
    parameter NBLK = 14,
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Generator first-row load port
    input wire i_gen_wr_en,
    input wire [3:0] i_gen_wr_addr,
    input wire [GEN_W-1:0] i_gen_wr_data,
    output wire o_gen_ready,
    // Frame bits from the upstream source
    input wire i_in_valid,
    input wire i_in_data,
    output wire o_in_ready,
    // Codeword bits to the sync marker logic
    output wire o_out_valid,
    output wire o_out_data,
    output wire o_out_first,
    output wire o_out_last,
    input wire i_out_ready,
    // Status
    output wire o_busy,
    output wire o_check_valid,
    output wire o_check_ok,
    output wire [CNT_W-1:0] o_frame_count
);

    localparam ST_IDLE = 3'd0;
    localparam ST_FILL = 3'd1;
    localparam ST_MSG = 3'd2;
    localparam ST_PAR = 3'd3;
    localparam ST_TAIL = 3'd4;

    localparam [8:0] POS_LAST = `LDE_CIRC_LAST;
    localparam [8:0] FILL_LAST = `LDE_FILL - 1;
    localparam [3:0] BLK_LAST = `LDE_NBLK_LAST;
    localparam [9:0] PAR_LAST = `LDE_PAR_LAST;
    localparam [9:0] CIRC10 = `LDE_CIRC;
    localparam [3:0] PAR_BLK = `LDE_NBLK;
    localparam [1:0] TAIL_LAST = `LDE_TAIL - 1;

    reg [2:0] state_reg, state_next;
    reg [8:0] pos_reg, pos_next;
    reg [3:0] blk_reg, blk_next;
    reg [9:0] pcnt_reg, pcnt_next;
    reg [1:0] tcnt_reg, tcnt_next;
    reg [GEN_W-1:0] gen_reg, gen_next;
    reg [GEN_W-1:0] acc_reg, acc_next;
    reg out_valid_reg, out_valid_next;
    reg out_data_reg, out_data_next;
    reg out_first_reg, out_first_next;
    reg out_last_reg, out_last_next;
    reg [NBLK-1:0] loaded_reg;
    reg chk_valid_reg;
    reg chk_ok_reg;
    reg [CNT_W-1:0] frame_cnt_reg;
    reg syn_en;
    reg syn_bit;
    reg [3:0] syn_blk;
    reg [8:0] syn_col;
    reg syn_clear;

    wire out_free;
    wire take_in;
    wire [GEN_W-1:0] gen_rd_data;
    wire [GEN_W-1:0] gen_wr_masked;
    wire [GEN_W-1:0] gen_rot;
    wire [3:0] rd_addr;
    wire syn_zero;

    // Right rotation of both generator halves by one row
    function [GEN_W-1:0] rot_halves;
        input [GEN_W-1:0] g;
        begin
            rot_halves = {g[1020:511], g[1021], g[509:0], g[510]};
        end
    endfunction

    // Output slot is free when empty or being drained
    assign out_free = !out_valid_reg || i_out_ready;
    assign take_in = (state_reg == ST_MSG) && out_free && i_in_valid;
    assign o_in_ready = (state_reg == ST_MSG) && out_free;
    assign gen_rot = rot_halves(gen_reg);

    // The two dependent parity elements never contribute
    assign gen_wr_masked = i_gen_wr_data & ~({{(GEN_W-1){1'b0}}, 1'b1} << `LDE_ZERO_EL0)
        & ~({{(GEN_W-1){1'b0}}, 1'b1} << `LDE_ZERO_EL1);

    // Next block's row is prefetched while the current block runs
    assign rd_addr = (state_reg == ST_MSG) ? (blk_reg + 4'd1) : 4'd0;

    lde_gen_mem #(
        .WIDTH(GEN_W),
        .DEPTH(NBLK),
        .AW(4)
    ) u_gen_mem (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_wr_en(i_gen_wr_en && (state_reg == ST_IDLE)),
        .i_wr_addr(i_gen_wr_addr),
        .i_wr_data(gen_wr_masked),
        .i_rd_addr(rd_addr),
        .o_rd_data(gen_rd_data)
    );

    lde_syn_check u_syn_check (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_clear(syn_clear),
        .i_en(syn_en),
        .i_bit(syn_bit),
        .i_blk(syn_blk),
        .i_col(syn_col),
        .o_zero(syn_zero)
    );

    // Sequencing of fill, message, parity and tail phases
    always @* begin
        state_next = state_reg;
        pos_next = pos_reg;
        blk_next = blk_reg;
        pcnt_next = pcnt_reg;
        tcnt_next = tcnt_reg;
        gen_next = gen_reg;
        acc_next = acc_reg;
        out_valid_next = out_valid_reg && !i_out_ready;
        out_data_next = out_data_reg;
        out_first_next = out_first_reg;
        out_last_next = out_last_reg;
        syn_en = 1'b0;
        syn_bit = 1'b0;
        syn_blk = blk_reg;
        syn_col = pos_reg;
        syn_clear = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (i_in_valid && (&loaded_reg) && !i_gen_wr_en) begin
                    state_next = ST_FILL;
                    acc_next = {GEN_W{1'b0}};
                    pos_next = 9'd0;
                    blk_next = 4'd0;
                    syn_clear = 1'b1;
                end
            end
            ST_FILL: begin
                // Virtual zeros only advance the row, nothing is emitted
                // Block 0 row taken in the first fill cycle, so a write just before start is seen
                gen_next = rot_halves((pos_reg == 9'd0) ? gen_rd_data : gen_reg);
                pos_next = pos_reg + 9'd1;
                if (pos_reg == FILL_LAST) begin
                    state_next = ST_MSG;
                end
            end
            ST_MSG: begin
                if (take_in) begin
                    out_valid_next = 1'b1;
                    out_data_next = i_in_data;
                    out_first_next = (blk_reg == 4'd0) && (pos_reg == `LDE_FILL);
                    out_last_next = 1'b0;
                    if (i_in_data) begin
                        acc_next = acc_reg ^ gen_reg;
                    end
                    syn_en = 1'b1;
                    syn_bit = i_in_data;
                    gen_next = gen_rot;
                    if (pos_reg == POS_LAST) begin
                        pos_next = 9'd0;
                        blk_next = blk_reg + 4'd1;
                        gen_next = gen_rd_data;
                        if (blk_reg == BLK_LAST) begin
                            state_next = ST_PAR;
                            pcnt_next = 10'd0;
                        end
                    end else begin
                        pos_next = pos_reg + 9'd1;
                    end
                end
            end
            ST_PAR: begin
                if (out_free) begin
                    out_valid_next = 1'b1;
                    out_data_next = acc_reg[0];
                    out_first_next = 1'b0;
                    acc_next = {1'b0, acc_reg[GEN_W-1:1]};
                    syn_en = 1'b1;
                    syn_bit = acc_reg[0];
                    if (pcnt_reg < CIRC10) begin
                        syn_blk = PAR_BLK;
                        syn_col = pcnt_reg[8:0];
                    end else begin
                        syn_blk = PAR_BLK + 4'd1;
                        syn_col = pcnt_reg[8:0] - 9'd511;
                    end
                    pcnt_next = pcnt_reg + 10'd1;
                    if (pcnt_reg == PAR_LAST) begin
                        state_next = ST_TAIL;
                        tcnt_next = 2'd0;
                    end
                end
            end
            ST_TAIL: begin
                if (out_free) begin
                    out_valid_next = 1'b1;
                    out_data_next = 1'b0;
                    out_first_next = 1'b0;
                    out_last_next = (tcnt_reg == TAIL_LAST);
                    tcnt_next = tcnt_reg + 2'd1;
                    if (tcnt_reg == TAIL_LAST) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Datapath and control registers
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            pos_reg <= 9'd0;
            blk_reg <= 4'd0;
            pcnt_reg <= 10'd0;
            tcnt_reg <= 2'd0;
            gen_reg <= {GEN_W{1'b0}};
            acc_reg <= {GEN_W{1'b0}};
            out_valid_reg <= 1'b0;
            out_data_reg <= 1'b0;
            out_first_reg <= 1'b0;
            out_last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pos_reg <= pos_next;
            blk_reg <= blk_next;
            pcnt_reg <= pcnt_next;
            tcnt_reg <= tcnt_next;
            gen_reg <= gen_next;
            acc_reg <= acc_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
            out_first_reg <= out_first_next;
            out_last_reg <= out_last_next;
        end
    end

    // Track which generator words hold a loaded row
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            loaded_reg <= {NBLK{1'b0}};
        end else if (i_gen_wr_en && (state_reg == ST_IDLE) && (i_gen_wr_addr < NBLK)) begin
            loaded_reg <= loaded_reg | ({{(NBLK-1){1'b0}}, 1'b1} << i_gen_wr_addr);
        end
    end

    // Self check verdict after the last parity bit, frame counter
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            chk_valid_reg <= 1'b0;
            chk_ok_reg <= 1'b0;
            frame_cnt_reg <= {CNT_W{1'b0}};
        end else begin
            chk_valid_reg <= 1'b0;
            if ((state_reg == ST_TAIL) && out_free && (tcnt_reg == TAIL_LAST)) begin
                chk_valid_reg <= 1'b1;
                chk_ok_reg <= syn_zero;
                frame_cnt_reg <= frame_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign o_out_valid = out_valid_reg;
    assign o_out_data = out_data_reg;
    assign o_out_first = out_first_reg;
    assign o_out_last = out_last_reg;
    assign o_gen_ready = &loaded_reg;
    assign o_busy = (state_reg != ST_IDLE);
    assign o_check_valid = chk_valid_reg;
    assign o_check_ok = chk_ok_reg;
    assign o_frame_count = frame_cnt_reg;

endmodule

// ---- tb/lde_encoder_properties.sv ----
// Port-level property checker for the LDPC encoder
`timescale 1ns/10ps
module lde_encoder_checker #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Frame and codeword streams
    input wire i_in_valid,
    input wire i_in_data,
    input wire o_in_ready,
    input wire o_out_valid,
    input wire o_out_data,
    input wire o_out_first,
    input wire o_out_last,
    input wire i_out_ready,
    // Status
    input wire o_busy,
    input wire o_gen_ready,
    input wire o_check_valid,
    input wire [CNT_W-1:0] o_frame_count
);
    reg [12:0] in_cnt_reg;
    reg [12:0] out_cnt_reg;
    wire in_fire = i_in_valid && o_in_ready;
    wire out_fire = o_out_valid && i_out_ready;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    // Bits moved through each port during the current frame
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            in_cnt_reg <= 13'h0000;
        end else if (out_fire && o_out_last) begin
            in_cnt_reg <= {12'h000, in_fire};
        end else if (in_fire) begin
            in_cnt_reg <= in_cnt_reg + 13'h0001;
        end
        if (!i_rstn) begin
            out_cnt_reg <= 13'h0000;
        end else if (out_fire) begin
            out_cnt_reg <= o_out_first ? 13'h0001 : out_cnt_reg + 13'h0001;
        end
    end

    AST_IN_SLOT: assert property (o_in_ready |-> o_busy && (!o_out_valid || i_out_ready))
        else $error("input ready without a free output slot");
    AST_OUT_HOLD: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_data) && $stable(o_out_last))
        else $error("output bit changed before it was taken");
    AST_PASS_THROUGH: assert property (in_fire |=> o_out_valid && o_out_data == $past(i_in_data))
        else $error("message bit not passed through unchanged");
    AST_FILL_WAIT: assert property ($rose(o_busy) |->
        !o_in_ready [*8] ##1 !o_in_ready [*8] ##1 !o_in_ready [*2] ##1 o_in_ready)
        else $error("fill phase not eighteen cycles");
    AST_IN_LIMIT: assert property (in_fire |-> in_cnt_reg < 13'd7136)
        else $error("more frame bits taken than one frame");
    AST_LAST_COUNT: assert property (out_fire && o_out_last |->
        out_cnt_reg == 13'd8159 && in_cnt_reg == 13'd7136 && !o_out_data)
        else $error("codeword length or tail bit wrong");
    AST_CHECK_PULSE: assert property (o_check_valid |-> o_out_valid && o_out_last ##1 !o_check_valid)
        else $error("check verdict not a pulse on the last bit");
    AST_IDLE_QUIET: assert property (!o_busy |-> !o_in_ready)
        else $error("input ready while idle");
    AST_GEN_STAYS: assert property (o_gen_ready |=> o_gen_ready)
        else $error("generator ready dropped without reset");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) !i_rstn |=>
        !o_out_valid && !o_busy && !o_gen_ready && o_frame_count == {CNT_W{1'b0}})
        else $error("state not cleared by reset");
endmodule

bind lde_encoder lde_encoder_checker #(.CNT_W(CNT_W)) u_lde_encoder_checker (.i_clk, .i_rstn, .i_in_valid,
    .i_in_data, .o_in_ready, .o_out_valid, .o_out_data, .o_out_first, .o_out_last, .i_out_ready, .o_busy,
    .o_gen_ready, .o_check_valid, .o_frame_count);

// ---- tb/lde_far_model.sv ----
// Frame source and codeword sink facing the encoder
`timescale 1ns/10ps
module lde_far_model (
    // Bench control
    input wire i_clk,
    input wire i_start,
    input wire i_stall,
    input wire [7135:0] i_msg,
    // Encoder input side
    output reg o_in_valid = 1'b0,
    output reg o_in_data = 1'b0,
    input wire i_in_ready,
    // Encoder output side
    input wire i_out_valid,
    input wire i_out_data,
    output reg o_out_ready = 1'b1,
    // Results; source idle until the first start
    output reg [8159:0] o_cw = '0,
    output integer o_sent = 7136,
    output integer o_rcvd = 0
);
    integer cyc = 0;
    reg fire = 1'b0;

    // Sample both handshakes and store delivered bits
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        fire <= o_in_valid && i_in_ready;
        if (i_start) begin
            o_rcvd <= 0;
        end else if (i_out_valid && o_out_ready) begin
            o_cw[o_rcvd] <= i_out_data;
            o_rcvd <= o_rcvd + 1;
        end
    end

    // Bits held until taken, 7136 per codeword, idle data toggles
    always @(negedge i_clk) begin
        o_out_ready <= !(i_stall && cyc % 7 == 2);
        if (i_start) begin
            o_sent = 0;
            o_in_valid = 1'b0;
        end else begin
            if (fire) begin
                o_sent = o_sent + 1;
            end
            if (fire || !o_in_valid) begin
                if (o_sent < 7136 && !(i_stall && cyc % 11 == 5)) begin
                    o_in_valid = 1'b1;
                    o_in_data = i_msg[o_sent];
                end else begin
                    o_in_valid = 1'b0;
                    o_in_data = ~o_in_data;
                end
            end
        end
    end
endmodule

// ---- tb/lde_encoder_tb_top.sv ----
// Self-checking bench for the LDPC encoder
`timescale 1ns/10ps
module lde_encoder_tb_top;
    reg i_clk = 1'b0;
    reg i_rstn = 1'b0;
    reg gen_wr_en = 1'b0;
    reg [3:0] gen_wr_addr = 4'h0;
    reg [1021:0] gen_wr_data = '0;
    reg start = 1'b0;
    reg stall = 1'b0;
    reg [7135:0] msg = '0;
    reg [1021:0] gw [0:13];
    wire in_valid, in_data, in_ready, out_valid, out_data, out_first, out_last, out_ready;
    wire gen_ready, busy, check_valid, check_ok;
    wire [15:0] frame_count;
    wire [8159:0] cw;
    integer sent, rcvd;
    integer mismatches = 0;
    integer n_tests = 0;
    integer first_at = -1;
    integer last_at = -1;

    always #5 i_clk = ~i_clk;

    // Codeword index at which the first and last flags were taken
    always @(posedge i_clk) begin
        if (start) begin
            first_at <= -1;
            last_at <= -1;
        end else begin
            if (out_valid && out_ready && out_first) first_at <= rcvd;
            if (out_valid && out_ready && out_last) last_at <= rcvd;
        end
    end

    lde_encoder u_lde_encoder (.i_clk(i_clk), .i_rstn(i_rstn), .i_gen_wr_en(gen_wr_en),
        .i_gen_wr_addr(gen_wr_addr), .i_gen_wr_data(gen_wr_data), .o_gen_ready(gen_ready),
        .i_in_valid(in_valid), .i_in_data(in_data), .o_in_ready(in_ready), .o_out_valid(out_valid),
        .o_out_data(out_data), .o_out_first(out_first), .o_out_last(out_last), .i_out_ready(out_ready),
        .o_busy(busy), .o_check_valid(check_valid), .o_check_ok(check_ok), .o_frame_count(frame_count));

    lde_far_model u_lde_far_model (.i_clk(i_clk), .i_start(start), .i_stall(stall), .i_msg(msg),
        .o_in_valid(in_valid), .o_in_data(in_data), .i_in_ready(in_ready), .i_out_valid(out_valid),
        .i_out_data(out_data), .o_out_ready(out_ready), .o_cw(cw), .o_sent(sent), .o_rcvd(rcvd));

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests = n_tests + 1;
        if (e !== g) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Reference codeword: info vector times rotated generator rows
    function automatic logic [8159:0] enc(input logic [7135:0] m);
        logic [1021:0] p;
        logic [1021:0] c;
        integer n;
        p = '0;
        c = '0;
        for (n = 0; n < 7154; n++) begin
            if (n % 511 == 0) c = gw[n / 511];
            if (n >= 18 && m[n - 18]) p = p ^ c;
            c = {c[1020:511], c[1021], c[509:0], c[510]};
        end
        return {2'b00, p, m};
    endfunction

    // Reset held four cycles, outputs checked while held
    task automatic do_reset;
        i_rstn <= 1'b0;
        repeat (4) @(negedge i_clk);
        chk("busy in reset", 0, busy);
        chk("gen ready in reset", 0, gen_ready);
        chk("out valid in reset", 0, out_valid);
        chk("frame count in reset", 0, frame_count);
        i_rstn <= 1'b1;
    endtask

    // Load 14 words; a write to address 14 is refused
    task automatic load_gen(input bit zero);
        logic [1023:0] v;
        integer i, a;
        for (i = 0; i < 15; i++) begin
            a = (i == 13) ? 14 : (i == 14) ? 13 : i;
            v = zero ? '0 : {32{32'h9e3779b9 ^ (i * 32'h01010101)}};
            v[510] = !zero;
            v[1021] = !zero;
            @(negedge i_clk);
            if (i == 14) chk("gen ready early", 0, gen_ready);
            gen_wr_en <= 1'b1;
            gen_wr_addr <= a[3:0];
            gen_wr_data <= v[1021:0];
            v[510] = 1'b0;
            v[1021] = 1'b0;
            if (a < 14) gw[a] = v[1021:0];
        end
        @(negedge i_clk) gen_wr_en <= 1'b0;
        @(negedge i_clk);
        chk("gen ready", 1, gen_ready);
    endtask

    // One codeword through the far-side model, judged bit for bit
    task automatic run_frame(input string nm, input bit stl, input bit okk, input logic oke, input logic [15:0] cnt);
        logic [8159:0] exp;
        integer k, bad;
        stall = stl;
        @(negedge i_clk) start <= 1'b1;
        @(negedge i_clk) start <= 1'b0;
        if (stl) begin
            repeat (30) @(negedge i_clk);
            gen_wr_en <= 1'b1;
            gen_wr_addr <= 4'h1;
            gen_wr_data <= ~gw[1];
            @(negedge i_clk) gen_wr_en <= 1'b0;
        end
        for (k = 0; k < 40000 && rcvd < 8160; k++) @(negedge i_clk);
        repeat (3) @(negedge i_clk);
        exp = enc(msg);
        bad = 8160;
        for (k = 8159; k >= 0; k--) if (cw[k] !== exp[k]) bad = k;
        chk({nm, " first bad bit"}, 8160, bad);
        chk("bits taken", 7136, sent);
        chk("bits delivered", 8160, rcvd);
        chk("first flag at", 0, first_at);
        chk("last flag at", 8159, last_at);
        if (okk) chk("syndrome verdict", oke, check_ok);
        chk("frame count", cnt, frame_count);
    endtask

    // Patterned frame with stalls both sides and a refused write
    task automatic t_stalled_frame;
        integer k;
        for (k = 0; k < 7136; k++) msg[k] = k[0] ^ k[3] ^ k[6] ^ k[10];
        run_frame("stalled", 1'b1, 1'b0, 1'b0, 16'h0001);
    endtask

    // All-zero frame right after; no parity carried over
    task automatic t_zero_frame;
        msg = '0;
        run_frame("zero", 1'b0, 1'b1, 1'b1, 16'h0002);
    endtask

    // Single last message bit, zero generator: parity zero, syndrome not
    task automatic t_single_bit;
        msg = '0;
        msg[7135] = 1'b1;
        run_frame("single", 1'b0, 1'b1, 1'b0, 16'h0001);
    endtask

    // Report counts and end the run
    task give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        do_reset;
        load_gen(1'b0);
        t_stalled_frame;
        t_zero_frame;
        do_reset;
        load_gen(1'b1);
        t_single_bit;
        give_verdict;
    end

    // Watchdog against a hang
    initial begin
        repeat (80000) @(posedge i_clk);
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule
